// file: verilog/rcr_pkg.sv
/*
 * rcr_pkg: constants shared by the reconnection release logic.
 * assumes one 200 MHz processing clock; register offsets are byte addresses.
 */
package rcr_pkg;
    localparam int          RCR_NUM_INST     = 2;
    localparam int          RCR_NUM_DEC      = 6;
    localparam int          RCR_CLK_MHZ      = 200;
    // default mains settle time; software rewrites the terminal count
    localparam int          RCR_SETTLE_MS    = 1000;
    localparam int          RCR_SETTLE_CYC   = RCR_SETTLE_MS * RCR_CLK_MHZ * 1000;

    // global registers
    localparam logic [7:0]  RCR_A_GCTRL      = 8'h00;
    localparam logic [7:0]  RCR_A_IRQ_STAT   = 8'h04;
    localparam logic [7:0]  RCR_A_IRQ_MASK   = 8'h08;
    localparam logic [7:0]  RCR_A_STATE      = 8'h0c;
    // per-instance block: base + stride * n
    localparam logic [7:0]  RCR_A_INST_BASE  = 8'h10;
    localparam logic [7:0]  RCR_A_INST_STEP  = 8'h10;
    localparam logic [3:0]  RCR_O_CTRL       = 4'h0;
    localparam logic [3:0]  RCR_O_VRANGE     = 4'h4;
    localparam logic [3:0]  RCR_O_FRANGE     = 4'h8;
    localparam logic [3:0]  RCR_O_SETTLE     = 4'hc;

    // instance control fields
    localparam int          RCR_F_COND       = 0;
    localparam int          RCR_F_AVG        = 2;
    localparam int          RCR_F_DECMASK    = 3;
    localparam int          RCR_F_DI_EN      = 9;
    localparam int          RCR_F_LOGIC_EN   = 10;
    localparam int          RCR_F_REMOTE     = 11;
    localparam int          RCR_CTRL_W       = 12;

    // interrupt status bits
    localparam int          RCR_I_REL0       = 0;
    localparam int          RCR_I_REL1       = 1;
    localparam int          RCR_I_TRIG0      = 2;
    localparam int          RCR_I_TRIG1      = 3;
    localparam int          RCR_IRQ_W        = 4;

    localparam logic [31:0] RCR_VRANGE_RST   = 32'hffff_0000;
    localparam logic [31:0] RCR_FRANGE_RST   = 32'hffff_0000;
    localparam logic [11:0] RCR_CTRL_RST     = 12'h000;

    typedef enum logic [1:0] {
        RCR_COND_INT,
        RCR_COND_EXT,
        RCR_COND_BOTH,
        RCR_COND_BOTH2
    } rcr_cond_t;
endpackage

// file: verilog/rcr_inst.sv
/*
 * rcr_inst: one reconnection release instance (range checks, settle timer, release).
 * assumes trigger, block, external release and reconnected inputs are already synchronous.
 */
`timescale 1ns/10ps
module rcr_inst (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 meas_tick_i,
    input  wire logic                 trig_i,
    input  wire logic [15:0]          v_rms_i,
    input  wire logic [15:0]          v_avg_i,
    input  wire logic [15:0]          freq_i,
    input  wire logic                 use_avg_i,
    input  wire rcr_pkg::rcr_cond_t   cond_i,
    input  wire logic [15:0]          v_lo_i,
    input  wire logic [15:0]          v_hi_i,
    input  wire logic [15:0]          f_lo_i,
    input  wire logic [15:0]          f_hi_i,
    input  wire logic [31:0]          settle_tc_i,
    input  wire logic                 ext_rel_i,
    input  wire logic                 block_i,
    input  wire logic                 reconnected_i,
    output logic                      release_o,
    output logic                      ok_o
);
    import rcr_pkg::*;

    typedef enum logic [1:0] {RCR_SETTLE, RCR_RELEASED, RCR_DONE} rcr_state_t;

    rcr_state_t  state_q;
    logic        v_ok_q;
    logic        f_ok_q;
    logic [31:0] cnt_q;
    logic        ok;
    logic        cnt_done;

    function automatic logic in_rng(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
        in_rng = (x >= lo) && (x <= hi);
    endfunction

    // checks are sampled only on a fresh measurement   see RULE_14
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            v_ok_q <= 1'b0;
            f_ok_q <= 1'b0;
        end else if (meas_tick_i) begin
            v_ok_q <= in_rng(use_avg_i ? v_avg_i : v_rms_i, v_lo_i, v_hi_i); // see RULE_04 see RULE_05
            f_ok_q <= in_rng(freq_i, f_lo_i, f_hi_i);                         // see RULE_06
        end
    end

    // frequency always stays internal; voltage comes from the selected source   see RULE_03
    always_comb begin
        case (cond_i)
            RCR_COND_INT: ok = v_ok_q & f_ok_q;
            RCR_COND_EXT: ok = ext_rel_i & f_ok_q;
            default:      ok = v_ok_q & f_ok_q & ext_rel_i;
        endcase
    end

    assign cnt_done = (cnt_q >= settle_tc_i);

    // any excursion or trigger restarts the settle time from zero   see RULE_08 see RULE_15
    always_ff @(posedge clk_i) begin
        if (rst_i || trig_i || !ok) begin
            cnt_q <= 32'h0000_0000;
        end else if (!cnt_done) begin
            cnt_q <= cnt_q + 32'h0000_0001;   // see RULE_07 see RULE_14
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || trig_i) begin
            state_q <= RCR_SETTLE;            // see RULE_15
        end else begin
            case (state_q)
                RCR_SETTLE: begin
                    if (cnt_done && ok && !block_i) begin
                        state_q <= RCR_RELEASED;   // see RULE_09 see RULE_10
                    end
                end
                RCR_RELEASED: begin
                    if (reconnected_i) begin
                        state_q <= RCR_DONE;       // see RULE_11
                    end else if (!ok || block_i) begin
                        state_q <= RCR_SETTLE;
                    end
                end
                // stays dropped until the next decoupling re-arms it
                RCR_DONE: state_q <= RCR_DONE;
                default:  state_q <= RCR_SETTLE;
            endcase
        end
    end

    assign release_o = (state_q == RCR_RELEASED);
    assign ok_o      = ok;
endmodule

// file: verilog/rcr_top.sv
/*
 * rcr_top: two reconnection release instances behind a classic wishbone slave.
 * assumes trips, logic signals and measurements are on clk_i; digital inputs,
 * external release and breaker position are pins.
 */
// Added by the designer: the address map and the Wishbone slave port.
// Contract
// RULE_01: two independent instances with own triggers, ranges and release.
// RULE_02: six assignable trips plus digital input, logic and remote triggers.
// RULE_03: voltage release internal, external coupling point, or both.
// RULE_04: line voltage checked against a configurable range.
// RULE_05: averaged method uses the one-minute average voltage.
// RULE_06: frequency range check is part of the internal release.
// RULE_07: release only after the full settle time, uninterrupted.
// RULE_08: any value out of range clears the settle timer.
// RULE_09: release needs no trigger, internal and any external release.
// RULE_10: logic-equation block keeps release from asserting.
// RULE_11: reconnected input drops the issued release.
// RULE_12: latch blocks instance two after a trip until instance one releases.
// RULE_13: both releases ORed into one relay output.
// RULE_14: timer counts clock ticks; checks run per measurement update.
// RULE_15: active trigger holds release low and timer cleared.
`timescale 1ns/10ps
module rcr_top #(
    parameter logic [31:0] SETTLE_RST_CYC = 32'(rcr_pkg::RCR_SETTLE_CYC)
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // classic wishbone slave
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    input  wire logic         we_i,
    input  wire logic [7:0]   adr_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic [31:0]  dat_i,
    output logic [31:0]       dat_o,
    output logic              ack_o,

    // measurements, one update strobe for both instances
    input  wire logic         meas_tick_i,
    input  wire logic [15:0]  v_rms_i,
    input  wire logic [15:0]  v_avg_i,
    input  wire logic [15:0]  freq_i,

    // decoupling trips, six per instance
    input  wire logic [5:0]   dec_trip0_i,
    input  wire logic [5:0]   dec_trip1_i,
    input  wire logic [1:0]   di_trig_i,
    input  wire logic [1:0]   logic_trig_i,
    input  wire logic [1:0]   block_i,
    input  wire logic [1:0]   external_coupling_point_release_i,
    input  wire logic [1:0]   reconnected_i,
    output logic [1:0]        release_out_o,
    output logic              release_any_o,
    output logic              irq_o
);
    import rcr_pkg::*;

    logic [31:0]           rdata_q;
    logic                  ack_q;
    logic                  wr;
    logic                  rd;

    logic                  scheme_q;
    logic                  latch_q;
    logic [RCR_IRQ_W-1:0]  irq_stat_q;
    logic [RCR_IRQ_W-1:0]  irq_mask_q;
    logic [RCR_IRQ_W-1:0]  irq_ev;

    logic [RCR_CTRL_W-1:0] ctrl_q   [RCR_NUM_INST];
    logic [31:0]           vrange_q [RCR_NUM_INST];
    logic [31:0]           frange_q [RCR_NUM_INST];
    logic [31:0]           settle_q [RCR_NUM_INST];

    logic [1:0]            di_s1_q;
    logic [1:0]            di_s2_q;
    logic [1:0]            ext_s1_q;
    logic [1:0]            ext_s2_q;
    logic [1:0]            rec_s1_q;
    logic [1:0]            rec_s2_q;

    logic [1:0]            trig;
    logic [1:0]            trig_d1_q;
    logic [1:0]            rel;
    logic [1:0]            rel_d1_q;
    logic [1:0]            ok;
    logic [1:0]            blk;

    // byte-lane merge for the per-instance writable registers
    function automatic logic [31:0] wmerge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  s
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        wmerge = r;
    endfunction

    // instance of an address, -1 outside the instance blocks
    function automatic int inst_of(input logic [7:0] a);
        inst_of = -1;
        for (int n = 0; n < RCR_NUM_INST; n++) begin
            if (a[7:4] == 4'((RCR_A_INST_BASE + 8'(n) * RCR_A_INST_STEP) >> 4)) begin
                inst_of = n;
            end
        end
    endfunction

    assign wr = cyc_i & stb_i & we_i & ~ack_q;
    assign rd = cyc_i & stb_i & ~we_i & ~ack_q;

    // pin inputs pass two flops before any logic reads them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            di_s1_q  <= 2'h0;
            di_s2_q  <= 2'h0;
            ext_s1_q <= 2'h0;
            ext_s2_q <= 2'h0;
            rec_s1_q <= 2'h0;
            rec_s2_q <= 2'h0;
        end else begin
            di_s1_q  <= di_trig_i;
            di_s2_q  <= di_s1_q;
            ext_s1_q <= external_coupling_point_release_i;
            ext_s2_q <= ext_s1_q;
            rec_s1_q <= reconnected_i;
            rec_s2_q <= rec_s1_q;
        end
    end

    // wishbone answers one cycle after the request, then drops ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            rdata_q <= 32'h0000_0000;
            case (adr_i)
                RCR_A_GCTRL:    rdata_q <= {31'h0, scheme_q};
                RCR_A_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
                RCR_A_IRQ_MASK: rdata_q <= {28'h0, irq_mask_q};
                RCR_A_STATE:    rdata_q <= {25'h0, latch_q, trig, ok, rel};
                default: begin
                    // unmapped addresses read as zero
                    if (inst_of(adr_i) >= 0 && adr_i[1:0] == 2'h0) begin
                        case (adr_i[3:0])
                            RCR_O_CTRL:   rdata_q <= {20'h0, ctrl_q[inst_of(adr_i)]};
                            RCR_O_VRANGE: rdata_q <= vrange_q[inst_of(adr_i)];
                            RCR_O_FRANGE: rdata_q <= frange_q[inst_of(adr_i)];
                            RCR_O_SETTLE: rdata_q <= settle_q[inst_of(adr_i)];
                            default:      rdata_q <= 32'h0000_0000;
                        endcase
                    end
                end
            endcase
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scheme_q   <= 1'b0;
            irq_mask_q <= 4'h0;
        end else if (wr && sel_i[0]) begin
            if (adr_i == RCR_A_GCTRL) begin
                scheme_q <= dat_i[0];
            end
            if (adr_i == RCR_A_IRQ_MASK) begin
                irq_mask_q <= dat_i[RCR_IRQ_W-1:0];
            end
        end
    end

    // each instance owns its own configuration   see RULE_01
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int n = 0; n < RCR_NUM_INST; n++) begin
                ctrl_q[n]   <= RCR_CTRL_RST;
                vrange_q[n] <= RCR_VRANGE_RST;
                frange_q[n] <= RCR_FRANGE_RST;
                settle_q[n] <= SETTLE_RST_CYC;
            end
        end else if (wr && inst_of(adr_i) >= 0 && adr_i[1:0] == 2'h0) begin
            case (adr_i[3:0])
                RCR_O_CTRL: begin
                    ctrl_q[inst_of(adr_i)] <=
                        RCR_CTRL_W'(wmerge({20'h0, ctrl_q[inst_of(adr_i)]}, dat_i, sel_i));
                end
                RCR_O_VRANGE: vrange_q[inst_of(adr_i)] <= wmerge(vrange_q[inst_of(adr_i)], dat_i, sel_i);
                RCR_O_FRANGE: frange_q[inst_of(adr_i)] <= wmerge(frange_q[inst_of(adr_i)], dat_i, sel_i);
                RCR_O_SETTLE: settle_q[inst_of(adr_i)] <= wmerge(settle_q[inst_of(adr_i)], dat_i, sel_i);
                default: ;
            endcase
        end
    end

    // assigned trips, digital input, logic equation, remote bit   see RULE_02
    always_comb begin
        trig[0] = |(dec_trip0_i & ctrl_q[0][RCR_F_DECMASK +: RCR_NUM_DEC])
                | (di_s2_q[0] & ctrl_q[0][RCR_F_DI_EN])
                | (logic_trig_i[0] & ctrl_q[0][RCR_F_LOGIC_EN])
                | ctrl_q[0][RCR_F_REMOTE];
        trig[1] = |(dec_trip1_i & ctrl_q[1][RCR_F_DECMASK +: RCR_NUM_DEC])
                | (di_s2_q[1] & ctrl_q[1][RCR_F_DI_EN])
                | (logic_trig_i[1] & ctrl_q[1][RCR_F_LOGIC_EN])
                | ctrl_q[1][RCR_F_REMOTE];
    end

    // set wins: a trip in the release cycle keeps instance two blocked   see RULE_12
    always_ff @(posedge clk_i) begin
        if (rst_i || !scheme_q) begin
            latch_q <= 1'b0;
        end else if (|(dec_trip0_i & ctrl_q[0][RCR_F_DECMASK +: RCR_NUM_DEC])) begin
            latch_q <= 1'b1;
        end else if (rel[0]) begin
            latch_q <= 1'b0;
        end
    end

    assign blk[0] = block_i[0];                 // see RULE_10
    assign blk[1] = block_i[1] | latch_q;       // see RULE_10 see RULE_12

    for (genvar g = 0; g < RCR_NUM_INST; g++) begin : g_inst
        rcr_inst u_inst (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .meas_tick_i   (meas_tick_i),
            .trig_i        (trig[g]),
            .v_rms_i       (v_rms_i),
            .v_avg_i       (v_avg_i),
            .freq_i        (freq_i),
            .use_avg_i     (ctrl_q[g][RCR_F_AVG]),
            .cond_i        (rcr_cond_t'(ctrl_q[g][RCR_F_COND +: 2])),
            .v_lo_i        (vrange_q[g][15:0]),
            .v_hi_i        (vrange_q[g][31:16]),
            .f_lo_i        (frange_q[g][15:0]),
            .f_hi_i        (frange_q[g][31:16]),
            .settle_tc_i   (settle_q[g]),
            .ext_rel_i     (ext_s2_q[g]),
            .block_i       (blk[g]),
            .reconnected_i (rec_s2_q[g]),
            .release_o     (rel[g]),
            .ok_o          (ok[g])
        );
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            release_out_o <= 2'h0;
            release_any_o <= 1'b0;
        end else begin
            release_out_o <= rel;
            release_any_o <= |rel;   // see RULE_13
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_d1_q <= 2'h0;
            rel_d1_q  <= 2'h0;
        end else begin
            trig_d1_q <= trig;
            rel_d1_q  <= rel;
        end
    end

    assign irq_ev[RCR_I_REL0]  = rel[0] & ~rel_d1_q[0];
    assign irq_ev[RCR_I_REL1]  = rel[1] & ~rel_d1_q[1];
    assign irq_ev[RCR_I_TRIG0] = trig[0] & ~trig_d1_q[0];
    assign irq_ev[RCR_I_TRIG1] = trig[1] & ~trig_d1_q[1];

    // write-one-to-clear, a new event in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= 4'h0;
        end else if (wr && sel_i[0] && adr_i == RCR_A_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~dat_i[RCR_IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule

// file: dv/rcr_top_props.sv
/* rcr_top_props: assertions on the ports of rcr_top.
   assumes the settle register keeps its reset value. */
`timescale 1ns/10ps
module rcr_top_props #(
    parameter logic [31:0] SETTLE_RST_CYC = 32'd20
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       irq_o,
    input wire logic [1:0] block_i,
    input wire logic [1:0] reconnected_i,
    input wire logic [1:0] release_out_o,
    input wire logic       release_any_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] low_q;
    // cycles release 0 has been low; bounds the settle time
    always_ff @(posedge clk_i) begin
        if (rst_i || release_out_o[0])
            low_q <= '0;
        else if (low_q != '1)
            low_q <= low_q + 32'd1;
    end
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_after_req: assert property (s_req |=> s_ack) else $error("ack late");
    a_ack_needs_req: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("stray ack");
    a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && release_out_o == 2'b00 && !release_any_o)
        else $error("not idle");
    a_any_is_or: assert property (release_any_o == (|release_out_o)) else $error("or wrong");
    a_block_low0: assert property (block_i[0] [*3] |-> !release_out_o[0]) else $error("blocked 0");
    a_block_low1: assert property (block_i[1] [*3] |-> !release_out_o[1]) else $error("blocked 1");
    a_reconn_drop: assert property (reconnected_i[0] [*6] |-> !release_out_o[0]) else $error("kept");
    a_settle_min: assert property ($rose(release_out_o[0]) |-> low_q >= SETTLE_RST_CYC) else $error("early");
endmodule

bind rcr_top rcr_top_props #(.SETTLE_RST_CYC(SETTLE_RST_CYC)) u_rcr_top_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o),
    .block_i(block_i), .reconnected_i(reconnected_i), .release_out_o(release_out_o),
    .release_any_o(release_any_o)
);

// file: dv/rcr_breaker_model.sv
/* rcr_breaker_model: two generator breakers closed by the release outputs.
   assumes arm_i low holds a breaker open. */
`timescale 1ns/10ps
module rcr_breaker_model #(
    parameter int CLOSE_CYC = 7
) (
    input  wire logic       clk_i,
    input  wire logic [1:0] arm_i,
    input  wire logic [1:0] release_i,
    output logic [1:0]      closed_o
);
    int cnt [2] = '{0, 0};
    initial closed_o = 2'b00;
    // the permission must stand for the whole closing time
    always @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            cnt[i] <= (arm_i[i] && release_i[i] && !closed_o[i]) ? cnt[i] + 1 : 0;
            closed_o[i] <= arm_i[i] && (closed_o[i] || (release_i[i] && cnt[i] == CLOSE_CYC));
        end
    end
endmodule

// file: dv/tb_rcr_top.sv
/* tb_rcr_top: self-checking bench for rcr_top with a breaker model on the release side.
   assumes a short settle count; every scenario starts from reset. */
`timescale 1ns/10ps
module tb_rcr_top;
    import rcr_pkg::*;
    localparam logic [31:0] SETTLE = 32'd20;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, meas_tick_i, ack_o, release_any_o, irq_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [15:0] v_rms_i, v_avg_i, freq_i;
    logic [5:0]  dec_trip0_i, dec_trip1_i;
    logic [1:0]  di_trig_i, logic_trig_i, block_i, ecp_rel, arm, reconnected, release_out_o;
    int          n_fail = 0, n_checks = 0, cyc_n = 0;

    rcr_top #(.SETTLE_RST_CYC(SETTLE)) u_rcr_top (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .meas_tick_i(meas_tick_i),
        .v_rms_i(v_rms_i), .v_avg_i(v_avg_i), .freq_i(freq_i), .dec_trip0_i(dec_trip0_i),
        .dec_trip1_i(dec_trip1_i), .di_trig_i(di_trig_i), .logic_trig_i(logic_trig_i), .block_i(block_i),
        .external_coupling_point_release_i(ecp_rel), .reconnected_i(reconnected),
        .release_out_o(release_out_o), .release_any_o(release_any_o), .irq_o(irq_o));
    rcr_breaker_model u_rcr_breaker_model (.clk_i(clk_i), .arm_i(arm), .release_i(release_out_o),
        .closed_o(reconnected));

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 10000) begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        {dec_trip0_i, dec_trip1_i, di_trig_i, logic_trig_i, block_i, ecp_rel, arm} <= '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // holds the request until ack, then idles a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    function automatic logic [7:0] ra(input int i, input logic [3:0] o);
        return RCR_A_INST_BASE + RCR_A_INST_STEP * 8'(i) + {4'h0, o};
    endfunction

    task automatic cfg(input int i, input logic [11:0] ctl, input logic [15:0] lo, input logic [15:0] hi);
        wb(1'b1, ra(i, RCR_O_CTRL), {20'h0, ctl});
        wb(1'b1, ra(i, RCR_O_VRANGE), {hi, lo});
        wb(1'b1, ra(i, RCR_O_FRANGE), {16'd510, 16'd490});
    endtask

    task automatic meas(input logic [15:0] v, input logic [15:0] va, input logic [15:0] f);
        @(posedge clk_i);
        {v_rms_i, v_avg_i, freq_i, meas_tick_i} <= {v, va, f, 1'b1};
        @(posedge clk_i);
        meas_tick_i <= 1'b0;
    endtask

    task automatic wait_rel(input int i, input logic v, input int lim, output int n);
        n = 0;
        while (release_out_o[i] !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // no release before the full settle count
    task automatic settle(input int i, input logic exp);
        int n;
        wait_rel(i, 1'b1, SETTLE + 10, n);
        chk("release", 32'(exp), 32'(release_out_o[i]));
        if (exp)
            chk("settle cycles", 32'h1, 32'(n >= SETTLE));
    endtask

    task automatic s_regs();
        logic [31:0] ex [4] = '{{20'h0, RCR_CTRL_RST}, RCR_VRANGE_RST, RCR_FRANGE_RST, SETTLE};
        do_reset();
        for (int k = 0; k < 4; k++) begin
            wb(1'b0, ra(1, 4'(4 * k)), 32'h0);
            chk("reset value", ex[k], rd);
        end
        wb(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, ra(1, RCR_O_VRANGE), 32'h00c8_0064);
        wb(1'b0, ra(1, RCR_O_VRANGE), 32'h0);
        chk("vrange", 32'h00c8_0064, rd);
    endtask

    task automatic s_internal();
        int n;
        do_reset();
        cfg(0, 12'h000, 16'd100, 16'd200);
        meas(16'd150, 16'd0, 16'd500);
        repeat (12) @(posedge clk_i);
        meas(16'd250, 16'd0, 16'd500);
        meas(16'd150, 16'd0, 16'd500);
        settle(0, 1'b1);
        meas(16'd250, 16'd0, 16'd500);
        wait_rel(0, 1'b0, 8, n);
        chk("out of range", 32'h2, 32'(release_out_o));
        meas(16'd200, 16'd0, 16'd510);
        settle(0, 1'b1);
        meas(16'd100, 16'd0, 16'd520);
        wait_rel(0, 1'b0, 8, n);
        chk("freq out", 32'h0, 32'(release_out_o[0]));
        chk("combined", 32'h1, 32'(release_any_o));
    endtask

    task automatic s_avg();
        int n;
        do_reset();
        cfg(0, 12'h004, 16'd100, 16'd200);
        meas(16'd250, 16'd150, 16'd500);
        settle(0, 1'b1);
        meas(16'd150, 16'd250, 16'd500);
        wait_rel(0, 1'b0, 8, n);
        chk("average out", 32'h0, 32'(release_out_o[0]));
    endtask

    task automatic s_cond();
        int cs [6] = '{0,1,1,2,2,3};
        int vs [6] = '{150,250,150,150,150,250};
        int es [6] = '{0,1,0,0,1,1};
        int xs [6] = '{1,1,0,0,1,0};
        for (int k = 0; k < 6; k++) begin
            do_reset();
            ecp_rel <= 2'(es[k]);
            cfg(0, 12'(cs[k]), 16'd100, 16'd200);
            meas(16'(vs[k]), 16'(vs[k]), 16'd500);
            settle(0, xs[k] != 0);
        end
    endtask

    task automatic trig(input int k, input logic on);
        if (k < 6)
            dec_trip0_i[k] <= on;
        else if (k == 6)
            di_trig_i[0] <= on;
        else if (k == 7)
            logic_trig_i[0] <= on;
        else
            wb(1'b1, ra(0, RCR_O_CTRL), on ? 32'hff8 : 32'h7f8);
    endtask

    task automatic s_trig();
        int n;
        do_reset();
        cfg(0, 12'h7f8, 16'd100, 16'd200);
        wb(1'b1, RCR_A_IRQ_MASK, 32'h4);
        meas(16'd150, 16'd0, 16'd500);
        settle(0, 1'b1);
        chk("irq masked", 32'h0, 32'(irq_o));
        for (int k = 0; k < 9; k++) begin
            trig(k, 1'b1);
            wait_rel(0, 1'b0, 8, n);
            repeat (SETTLE + 8) @(posedge clk_i);
            chk("trigger holds", 32'h2, 32'(release_out_o));
            if (k == 0) begin
                chk("irq", 32'h1, 32'(irq_o));
                wb(1'b1, RCR_A_IRQ_STAT, 32'h4);
                chk("irq clear", 32'h0, 32'(irq_o));
            end
            trig(k, 1'b0);
            settle(0, 1'b1);
        end
    endtask

    task automatic s_block();
        int n;
        do_reset();
        block_i <= 2'b01;
        cfg(0, 12'h000, 16'd100, 16'd200);
        meas(16'd150, 16'd0, 16'd500);
        settle(0, 1'b0);
        block_i <= 2'b00;
        wait_rel(0, 1'b1, 6, n);
        chk("unblocked", 32'h1, 32'(release_out_o[0]));
        block_i <= 2'b11;
        wait_rel(0, 1'b0, 6, n);
        chk("blocked", 32'h0, 32'(release_out_o));
    endtask

    task automatic s_reconn();
        int n;
        do_reset();
        arm <= 2'b01;
        cfg(0, 12'h000, 16'd100, 16'd200);
        meas(16'd150, 16'd0, 16'd500);
        settle(0, 1'b1);
        wait_rel(0, 1'b0, 20, n);
        chk("reconnected", 32'h0, 32'(release_out_o[0]));
        repeat (SETTLE + 8) @(posedge clk_i);
        chk("stays dropped", 32'h0, 32'(release_out_o[0]));
    endtask

    task automatic s_latch();
        int n;
        do_reset();
        wb(1'b1, RCR_A_GCTRL, 32'h1);
        cfg(0, 12'h1f8, 16'd100, 16'd200);
        dec_trip0_i <= 6'h04;
        meas(16'd150, 16'd0, 16'd500);
        repeat (SETTLE + 8) @(posedge clk_i);
        chk("latched", 32'h0, 32'(release_out_o));
        dec_trip0_i <= 6'h00;
        settle(0, 1'b1);
        wait_rel(1, 1'b1, SETTLE + 10, n);
        chk("latch cleared", 32'h3, 32'(release_out_o));
    endtask

    initial begin
        {clk_i, rst_i, cyc_i, stb_i, we_i, meas_tick_i} = 6'b010000;
        {adr_i, sel_i, dat_i} = {8'h00, 4'hf, 32'h0};
        {v_rms_i, v_avg_i, freq_i} = '0;
        {dec_trip0_i, dec_trip1_i, di_trig_i, logic_trig_i, block_i, ecp_rel, arm} = '0;
        s_regs();
        s_internal();
        s_avg();
        s_cond();
        s_trig();
        s_block();
        s_reconn();
        s_latch();
        end_of_test();
    end
endmodule
